/* hw/spims_cfg.svh */
`ifndef SPIMS_CFG_SVH
`define SPIMS_CFG_SVH
// register offsets in data space
`define SPIMS_CTRL_OFS 8'h4C
`define SPIMS_STAT_OFS 8'h4D
`define SPIMS_DATA_OFS 8'h4E
// io space sits this far below data space
`define SPIMS_IO_SHIFT 8'h20
// reset values
`define SPIMS_CTRL_RST 8'h00
`define SPIMS_STAT_RST 8'h00
// status field positions
`define SPIMS_STAT_FLAG_BIT 7
`define SPIMS_STAT_WCOL_BIT 6
`define SPIMS_STAT_DBL_BIT 0
// half period of sck minus one, in core clocks
`define SPIMS_HALF_DIV2 6'h00
`define SPIMS_HALF_DIV4 6'h01
`define SPIMS_HALF_DIV8 6'h03
`define SPIMS_HALF_DIV16 6'h07
`define SPIMS_HALF_DIV32 6'h0F
`define SPIMS_HALF_DIV64 6'h1F
`define SPIMS_HALF_DIV128 6'h3F
// last edge index of a byte (16 edges)
`define SPIMS_LAST_EDGE 4'hF
// receive fifo shape
`define SPIMS_FIFO_DEPTH 8
`define SPIMS_FIFO_AW 3
`endif

/* hw/spims_pkg.sv */
package spims_pkg;
	// control register layout, bit 7 down to 0
	typedef struct packed {
		logic spie; // xfer_irq_enable
		logic en; // unit_enable
		logic lsb_first; // bit_order_select
		logic master; // master_role_select
		logic cpol; // clock_idle_polarity
		logic cpha; // clock_sample_phase
		logic [1:0] rate; // rate_select_hi, rate_select_lo
	} spims_ctrl_type;
	// serial pins as seen from outside
	typedef struct packed {
		logic ss_n;
		logic miso;
		logic mosi;
		logic sck;
	} spims_pins_type;
	// transfer engine states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_MASTER,
		ST_SLAVE
	} spims_st_type;
endpackage : spims_pkg

/* hw/spims_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module spims_sync #(
	parameter int W = 4
) (
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	// two stage synchroniser state
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} spims_sync_type;
	spims_sync_type sync_ff;
	spims_sync_type nxt_sync;
	// first stage feeds only the second
	always_comb begin
		nxt_sync = sync_ff;
		if (ce_i) begin
			nxt_sync.meta = async_i;
			nxt_sync.stable = sync_ff.meta;
		end
	end
	// register stage, idle high so select reads inactive
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sync_ff <= '1;
		end else begin
			sync_ff <= nxt_sync;
		end
	end
	assign sync_o = sync_ff.stable;
endmodule : spims_sync
`default_nettype wire

/* hw/spims_fifo.sv */
`timescale 1ns/1ns
`default_nettype none
module spims_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8,
	parameter int AW = 3
) (
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	// whole fifo state including storage
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wptr;
		logic [AW-1:0] rptr;
		logic [AW:0] count;
		logic [WIDTH-1:0] head; // registered read data
	} spims_fifo_type;
	spims_fifo_type fifo_ff;
	spims_fifo_type nxt_fifo;
	logic do_push;
	logic do_pop;
	// pointer, count and head update
	always_comb begin
		nxt_fifo = fifo_ff;
		do_push = in_valid_i && in_ready_o;
		do_pop = out_ready_i && out_valid_o;
		if (ce_i) begin
			if (do_push) begin
				nxt_fifo.mem[fifo_ff.wptr] = in_data_i;
				nxt_fifo.wptr = AW'(fifo_ff.wptr + 1'b1);
			end
			if (do_pop) begin
				nxt_fifo.rptr = AW'(fifo_ff.rptr + 1'b1);
			end
			// count follows push and pop
			if (do_push && !do_pop) begin
				nxt_fifo.count = (AW+1)'(fifo_ff.count + 1'b1);
			end else if (do_pop && !do_push) begin
				nxt_fifo.count = (AW+1)'(fifo_ff.count - 1'b1);
			end
			// head shows next oldest word, bypassing a fresh write
			nxt_fifo.head = nxt_fifo.mem[nxt_fifo.rptr];
		end
	end
	// storage register
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			fifo_ff <= '0;
		end else begin
			fifo_ff <= nxt_fifo;
		end
	end
	assign in_ready_o = (fifo_ff.count != (AW+1)'(DEPTH));
	assign out_valid_o = (fifo_ff.count != '0);
	assign out_data_o = fifo_ff.head;
endmodule : spims_fifo
`default_nettype wire

/* hw/spims_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "spims_cfg.svh"
module spims_top (
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	input wire logic [7:0] bus_addr_i,
	input wire logic bus_io_space_i,
	input wire logic bus_wr_i,
	input wire logic bus_rd_i,
	input wire logic [7:0] bus_wdata_i,
	output logic [7:0] bus_rdata_o,
	input wire logic gie_i,
	input wire logic irq_ack_i,
	output logic irq_o,
	input wire logic ddr_sck_i,
	input wire logic ddr_mosi_i,
	input wire logic ddr_miso_i,
	input wire logic ddr_ss_i,
	input wire logic sck_i,
	output logic sck_o,
	output logic sck_oe_n_o,
	input wire logic mosi_i,
	output logic mosi_o,
	output logic mosi_oe_n_o,
	input wire logic miso_i,
	output logic miso_o,
	output logic miso_oe_n_o,
	input wire logic ss_n_i
);
	// complete block state
	typedef struct packed {
		spims_pkg::spims_ctrl_type ctrl; // serial_port_control
		logic dbl; // double_rate_bit
		logic flag; // xfer_done_flag
		logic wcol; // write collision
		logic armed; // status read seen with flag or collision up
		spims_pkg::spims_st_type st;
		logic [5:0] div; // sck half period counter
		logic [3:0] edge_cnt; // sck edges in this byte
		logic [7:0] tx; // transmit shifter
		logic [7:0] rx; // receive shifter
		logic sck_prev; // last sampled sck in slave role
		logic start_pend; // master byte waiting to go
		logic push; // fifo push pulse
		logic [7:0] push_data;
		logic [7:0] rdata;
		logic irq;
		logic sck;
		logic sck_oe_n;
		logic mosi;
		logic mosi_oe_n;
		logic miso;
		logic miso_oe_n;
	} spims_state_type;
	spims_state_type state_ff;
	spims_state_type nxt_state;
	spims_pkg::spims_pins_type pins_raw; // pins before crossing
	spims_pkg::spims_pins_type pins_s; // pins after crossing
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_pop;
	logic [7:0] fifo_head;
	// working values of the next-state process
	logic [7:0] eff_addr;
	logic hit_ctrl;
	logic hit_stat;
	logic hit_data;
	logic [5:0] half;
	logic tick;
	logic is_lead;
	logic sample;
	logic done;
	logic din;
	logic busy;
	logic [7:0] rx_new;

	assign pins_raw = '{ss_n: ss_n_i, miso: miso_i, mosi: mosi_i, sck: sck_i};

	// pin inputs cross into the core clock
	spims_sync #(
		.W(4)
	) u_sync (
		.core_clk_i(core_clk_i),
		.reset_n_i(reset_n_i),
		.ce_i(ce_i),
		.async_i(pins_raw),
		.sync_o(pins_s)
	);

	// received bytes queue; full stalls the next master byte
	spims_fifo #(
		.WIDTH(8),
		.DEPTH(`SPIMS_FIFO_DEPTH),
		.AW(`SPIMS_FIFO_AW)
	) u_rx_fifo (
		.core_clk_i(core_clk_i),
		.reset_n_i(reset_n_i),
		.ce_i(ce_i),
		.in_valid_i(state_ff.push),
		.in_ready_o(fifo_in_ready),
		.in_data_i(state_ff.push_data),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(fifo_pop),
		.out_data_o(fifo_head)
	);

	// a data register read drains one byte
	assign fifo_pop = ce_i && bus_rd_i && hit_data;

	// address decode for both address spaces
	always_comb begin
		eff_addr = bus_io_space_i ? 8'(bus_addr_i + `SPIMS_IO_SHIFT) : bus_addr_i;
		hit_ctrl = (eff_addr == `SPIMS_CTRL_OFS);
		hit_stat = (eff_addr == `SPIMS_STAT_OFS);
		hit_data = (eff_addr == `SPIMS_DATA_OFS);
	end

	// sck half period from rate and double bits
	always_comb begin
		case ({state_ff.dbl, state_ff.ctrl.rate})
			3'b000: half = `SPIMS_HALF_DIV4;
			3'b001: half = `SPIMS_HALF_DIV16;
			3'b010: half = `SPIMS_HALF_DIV64;
			3'b011: half = `SPIMS_HALF_DIV128;
			3'b100: half = `SPIMS_HALF_DIV2;
			3'b101: half = `SPIMS_HALF_DIV8;
			3'b110: half = `SPIMS_HALF_DIV32;
			3'b111: half = `SPIMS_HALF_DIV64;
			default: half = `SPIMS_HALF_DIV4;
		endcase
	end

	// next state of registers, engine and pins
	always_comb begin
		nxt_state = state_ff;
		tick = 1'b0;
		is_lead = 1'b0;
		sample = 1'b0;
		done = 1'b0;
		din = 1'b0;
		rx_new = state_ff.rx;
		busy = (state_ff.st == spims_pkg::ST_MASTER) || state_ff.start_pend
			|| (state_ff.st == spims_pkg::ST_SLAVE && state_ff.edge_cnt != 4'h0);
		if (ce_i) begin
			nxt_state.push = 1'b0;
			nxt_state.sck_prev = pins_s.sck;
			// status then data access clears flag and collision
			if ((bus_rd_i || bus_wr_i) && hit_data && state_ff.armed) begin
				nxt_state.flag = 1'b0;
				nxt_state.wcol = 1'b0;
				nxt_state.armed = 1'b0;
			end
			// interrupt vector taken
			if (irq_ack_i) begin
				nxt_state.flag = 1'b0;
			end
			if (bus_rd_i && hit_stat) begin
				nxt_state.armed = state_ff.flag || state_ff.wcol;
			end
			// register writes
			if (bus_wr_i && hit_ctrl) begin
				nxt_state.ctrl = bus_wdata_i;
			end
			if (bus_wr_i && hit_stat) begin
				nxt_state.dbl = bus_wdata_i[`SPIMS_STAT_DBL_BIT];
			end
			if (bus_wr_i && hit_data) begin
				if (busy) begin
					nxt_state.wcol = 1'b1;
				end else begin
					nxt_state.tx = bus_wdata_i;
					nxt_state.start_pend = state_ff.ctrl.en && state_ff.ctrl.master;
				end
			end
			// engine
			if (!state_ff.ctrl.en) begin
				nxt_state.st = spims_pkg::ST_IDLE;
				nxt_state.edge_cnt = 4'h0;
				nxt_state.start_pend = 1'b0;
				// idle level follows a polarity written this cycle, no glitch on enable
				nxt_state.sck = nxt_state.ctrl.cpol;
			end else if (state_ff.ctrl.master && !ddr_ss_i && !pins_s.ss_n) begin
				// another master selected us: give up the bus
				nxt_state.ctrl.master = 1'b0;
				nxt_state.flag = 1'b1;
				nxt_state.st = spims_pkg::ST_IDLE;
				nxt_state.edge_cnt = 4'h0;
				nxt_state.start_pend = 1'b0;
				nxt_state.sck = nxt_state.ctrl.cpol;
			end else if (state_ff.ctrl.master) begin
				// select pin as output is not looked at here
				din = pins_s.miso;
				if (state_ff.st != spims_pkg::ST_MASTER) begin
					nxt_state.sck = nxt_state.ctrl.cpol;
					nxt_state.edge_cnt = 4'h0;
					nxt_state.div = 6'h00;
					nxt_state.st = spims_pkg::ST_IDLE;
					// start only while the queue has room
					if (state_ff.start_pend && fifo_in_ready) begin
						nxt_state.st = spims_pkg::ST_MASTER;
						nxt_state.start_pend = 1'b0;
					end
				end else if (state_ff.div == half) begin
					tick = 1'b1;
					nxt_state.div = 6'h00;
					nxt_state.sck = !state_ff.sck;
					is_lead = !state_ff.edge_cnt[0];
				end else begin
					nxt_state.div = 6'(state_ff.div + 1'b1);
				end
			end else begin
				din = pins_s.mosi;
				if (pins_s.ss_n) begin
					// deselected: passive, partial byte dropped
					nxt_state.st = spims_pkg::ST_IDLE;
					nxt_state.edge_cnt = 4'h0;
					nxt_state.rx = 8'h00;
				end else begin
					nxt_state.st = spims_pkg::ST_SLAVE;
					if (state_ff.st == spims_pkg::ST_SLAVE && pins_s.sck != state_ff.sck_prev) begin
						tick = 1'b1;
						is_lead = (state_ff.sck_prev == state_ff.ctrl.cpol);
					end
				end
			end
			// shared edge handling for both roles
			if (tick) begin
				sample = is_lead ^ state_ff.ctrl.cpha;
				if (sample) begin
					rx_new = state_ff.ctrl.lsb_first ? {din, state_ff.rx[7:1]}
						: {state_ff.rx[6:0], din};
				end else if (!(state_ff.ctrl.cpha && state_ff.edge_cnt == 4'h0)) begin
					// setup edge, opposite to sampling
					nxt_state.tx = state_ff.ctrl.lsb_first ? {1'b0, state_ff.tx[7:1]}
						: {state_ff.tx[6:0], 1'b0};
				end
				nxt_state.rx = rx_new;
				nxt_state.edge_cnt = 4'(state_ff.edge_cnt + 1'b1);
				if (state_ff.st == spims_pkg::ST_MASTER) begin
					// sixteen edges end the byte at idle level
					done = (state_ff.edge_cnt == `SPIMS_LAST_EDGE);
				end else begin
					done = sample && (state_ff.edge_cnt[3:1] == 3'h7);
				end
			end
			// byte complete
			if (done) begin
				nxt_state.flag = 1'b1;
				nxt_state.push = 1'b1;
				nxt_state.push_data = rx_new;
				nxt_state.edge_cnt = 4'h0;
				if (state_ff.st == spims_pkg::ST_MASTER) begin
					nxt_state.st = spims_pkg::ST_IDLE;
				end
			end
			// read data, one cycle after the strobe
			if (bus_rd_i) begin
				if (hit_ctrl) begin
					nxt_state.rdata = state_ff.ctrl;
				end else if (hit_stat) begin
					nxt_state.rdata = 8'h00;
					nxt_state.rdata[`SPIMS_STAT_FLAG_BIT] = state_ff.flag;
					nxt_state.rdata[`SPIMS_STAT_WCOL_BIT] = state_ff.wcol;
					nxt_state.rdata[`SPIMS_STAT_DBL_BIT] = state_ff.dbl;
				end else if (hit_data) begin
					nxt_state.rdata = fifo_head;
				end else begin
					nxt_state.rdata = 8'h00;
				end
			end
			// pin drivers, enables low while driving
			nxt_state.mosi = nxt_state.ctrl.lsb_first ? nxt_state.tx[0] : nxt_state.tx[7];
			nxt_state.miso = nxt_state.mosi;
			nxt_state.sck_oe_n = !(nxt_state.ctrl.en && nxt_state.ctrl.master && ddr_sck_i);
			nxt_state.mosi_oe_n = !(nxt_state.ctrl.en && nxt_state.ctrl.master && ddr_mosi_i);
			nxt_state.miso_oe_n = !(nxt_state.ctrl.en && !nxt_state.ctrl.master
				&& !pins_s.ss_n && ddr_miso_i);
			// interrupt request
			nxt_state.irq = nxt_state.flag && nxt_state.ctrl.spie && gie_i;
		end
	end

	// state register
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_ff <= '0;
			state_ff.ctrl <= `SPIMS_CTRL_RST;
			state_ff.sck_oe_n <= 1'b1;
			state_ff.mosi_oe_n <= 1'b1;
			state_ff.miso_oe_n <= 1'b1;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// outputs straight from the state register
	assign bus_rdata_o = state_ff.rdata;
	assign irq_o = state_ff.irq;
	assign sck_o = state_ff.sck;
	assign sck_oe_n_o = state_ff.sck_oe_n;
	assign mosi_o = state_ff.mosi;
	assign mosi_oe_n_o = state_ff.mosi_oe_n;
	assign miso_o = state_ff.miso;
	assign miso_oe_n_o = state_ff.miso_oe_n;
endmodule : spims_top
`default_nettype wire

/* tb/spims_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
// port-level watch over the spi unit
module spims_monitor (
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	input wire logic [7:0] bus_addr_i,
	input wire logic bus_io_space_i,
	input wire logic bus_wr_i,
	input wire logic bus_rd_i,
	input wire logic [7:0] bus_wdata_i,
	input wire logic [7:0] bus_rdata_o,
	input wire logic gie_i,
	input wire logic irq_ack_i,
	input wire logic irq_o,
	input wire logic ddr_ss_i,
	input wire logic ss_n_i,
	input wire logic sck_oe_n_o,
	input wire logic mosi_oe_n_o,
	input wire logic miso_oe_n_o
);
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!reset_n_i);
	// control write that cannot trip master role
	sequence s_wr_ctrl;
		ce_i && bus_wr_i && bus_addr_i == 8'h4C && !bus_io_space_i && !bus_wdata_i[4];
	endsequence
	// control read in data space
	sequence s_rd_ctrl;
		ce_i && bus_rd_i && bus_addr_i == 8'h4C && !bus_io_space_i;
	endsequence
	// master driving while its select input is pulled low
	sequence s_fault_seen;
		(!sck_oe_n_o && !ddr_ss_i && !ss_n_i) [*3];
	endsequence
	property p_ctrl_back;
		s_wr_ctrl ##2 s_rd_ctrl |=> bus_rdata_o == $past(bus_wdata_i, 3);
	endproperty
	a_ctrl_back: assert property (p_ctrl_back) else $error("control readback wrong");
	property p_unmapped;
		ce_i && bus_rd_i && bus_addr_i == 8'h10 && !bus_io_space_i |=> bus_rdata_o == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_rdata_hold;
		!$past(bus_rd_i) |-> $stable(bus_rdata_o);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
	property p_irq_gie;
		irq_o |-> $past(gie_i);
	endproperty
	a_irq_gie: assert property (p_irq_gie) else $error("irq without global enable");
	property p_irq_ack;
		irq_ack_i |-> ##2 !irq_o;
	endproperty
	a_irq_ack: assert property (p_irq_ack) else $error("irq kept after ack");
	property p_miso_role;
		!miso_oe_n_o |-> sck_oe_n_o && mosi_oe_n_o;
	endproperty
	a_miso_role: assert property (p_miso_role) else $error("slave drives clock or mosi");
	property p_ss_release;
		$rose(ss_n_i) |-> ##[1:4] miso_oe_n_o;
	endproperty
	a_ss_release: assert property (p_ss_release) else $error("miso kept after deselect");
	property p_fault;
		s_fault_seen |-> ##[0:3] (sck_oe_n_o && mosi_oe_n_o);
	endproperty
	a_fault: assert property (p_fault) else $error("mode fault kept driving");
endmodule : spims_monitor
bind spims_top spims_monitor spims_monitor_inst (
	.core_clk_i, .reset_n_i, .ce_i, .bus_addr_i, .bus_io_space_i, .bus_wr_i,
	.bus_rd_i, .bus_wdata_i, .bus_rdata_o, .gie_i, .irq_ack_i, .irq_o,
	.ddr_ss_i, .ss_n_i, .sck_oe_n_o, .mosi_oe_n_o, .miso_oe_n_o
);
`default_nettype wire

/* tb/spims_slave_model.sv */
`timescale 1ns/1ns
`default_nettype none
// behavioural far-side spi slave
module spims_slave_model (
	input wire logic sck_i,
	input wire logic mosi_i,
	input wire logic ss_n_i,
	input wire logic [1:0] mode_i,
	input wire logic lsb_i,
	input wire logic [7:0] tx_i,
	output logic miso_o,
	output logic [7:0] rx_o
);
	logic [7:0] sh; // receive shifter
	int k; // bits presented so far
	// bit i of the outgoing byte in wire order
	function automatic logic bit_at(input int i);
		bit_at = lsb_i ? tx_i[i] : tx_i[7 - i];
	endfunction : bit_at
	initial miso_o = 1'b0;
	// selection presents the first bit when phase is 0
	always @(negedge ss_n_i) begin
		k = mode_i[0] ? 0 : 1;
		if (!mode_i[0]) miso_o = bit_at(0);
	end
	// released line shows the inverse of its last level
	always @(posedge ss_n_i) miso_o = !miso_o;
	// sample on one edge, set up on the other
	always @(sck_i) if (!ss_n_i) begin
		if (sck_i == !(mode_i[1] ^ mode_i[0])) begin
			sh = lsb_i ? {mosi_i, sh[7:1]} : {sh[6:0], mosi_i};
			rx_o = sh;
		end else if (k < 8) begin
			miso_o = bit_at(k);
			k++;
		end
	end
endmodule : spims_slave_model
`default_nettype wire

/* tb/spims_top_test.sv */
`timescale 1ns/1ns
`default_nettype none
// self-checking bench for the spi unit
module spims_top_test;
	logic core_clk = 1'b0, reset_n = 1'b0, io = 1'b0, wr_s = 1'b0, rd_s = 1'b0;
	logic gie = 1'b0, ack = 1'b0, ddr_ss = 1'b1, ss_n = 1'b1, tb_sck = 1'b0, tb_mosi = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, m_tx = 8'h00, m_rx;
	logic irq, sck_o, sck_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n, m_miso, lsb = 1'b0;
	logic sck_w, mosi_w, miso_w;
	logic [1:0] mode = 2'b00;
	int fail_count = 0, compares = 0, cycles = 0, edges = 0;
	time t0, t1;
	// resolved pin levels
	assign sck_w = !sck_oe_n ? sck_o : tb_sck;
	assign mosi_w = !mosi_oe_n ? mosi_o : tb_mosi;
	assign miso_w = !miso_oe_n ? miso_o : m_miso;
	always #5 core_clk = !core_clk;
	spims_top spims_top_inst (.core_clk_i(core_clk), .reset_n_i(reset_n), .ce_i(1'b1),
		.bus_addr_i(addr), .bus_io_space_i(io), .bus_wr_i(wr_s), .bus_rd_i(rd_s),
		.bus_wdata_i(wdata), .bus_rdata_o(rdata), .gie_i(gie), .irq_ack_i(ack), .irq_o(irq),
		.ddr_sck_i(1'b1), .ddr_mosi_i(1'b1), .ddr_miso_i(1'b1), .ddr_ss_i(ddr_ss),
		.sck_i(sck_w), .sck_o(sck_o), .sck_oe_n_o(sck_oe_n), .mosi_i(mosi_w), .mosi_o(mosi_o),
		.mosi_oe_n_o(mosi_oe_n), .miso_i(miso_w), .miso_o(miso_o), .miso_oe_n_o(miso_oe_n),
		.ss_n_i(ss_n));
	spims_slave_model spims_slave_model_inst (.sck_i(sck_w), .mosi_i(mosi_w), .ss_n_i(ss_n),
		.mode_i(mode), .lsb_i(lsb), .tx_i(m_tx), .miso_o(m_miso), .rx_o(m_rx));
	// clock edge count and first half period
	always @(sck_w) begin
		if (edges == 0) t0 = $time;
		if (edges == 1) t1 = $time;
		edges++;
	end
	// hang guard
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			end_of_test();
		end
	end
	task automatic end_of_test();
		if (fail_count == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : end_of_test
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	// bus cycles, entered and left at a falling edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		addr = a;
		wdata = d;
		io = 1'b0;
		wr_s = 1'b1;
		@(negedge core_clk);
		wr_s = 1'b0;
		// one idle edge so a following strobe never retoggles in this step
		@(negedge core_clk);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d, input logic s = 1'b0);
		addr = a;
		io = s;
		rd_s = 1'b1;
		@(negedge core_clk);
		rd_s = 1'b0;
		d = rdata;
		@(negedge core_clk);
	endtask : rd
	task automatic wait_flag();
		logic [7:0] s;
		for (int i = 0; i < 300; i++) begin
			rd(8'h4D, s);
			if (s[7]) return;
		end
		check("done flag", 8'h80, s);
	endtask : wait_flag
	// reset values, access, unmapped place, disabled unit
	task automatic t_regs();
		logic [7:0] d;
		rd(8'h4C, d);
		check("ctrl reset", 8'h00, d);
		wr(8'h4C, 8'h2D);
		rd(8'h4C, d);
		check("ctrl rw", 8'h2D, d);
		rd(8'h2C, d, 1'b1);
		check("ctrl io", 8'h2D, d);
		rd(8'h10, d);
		check("unmapped", 8'h00, d);
		wr(8'h4E, 8'h77);
		repeat (40) @(negedge core_clk);
		rd(8'h4D, d);
		check("off status", 8'h00, d);
		check("off sck", 8'h01, {7'h00, sck_oe_n});
	endtask : t_regs
	// one master byte in mode m
	task automatic t_master(input logic [1:0] m);
		logic [7:0] d;
		mode = m;
		lsb = m[0];
		m_tx = 8'h61 + {6'h00, m};
		wr(8'h4C, {2'b01, m[0], 1'b1, m, 2'b01});
		// double rate only in mode 3; also lets sck settle at its idle level
		wr(8'h4D, {7'h00, &m});
		repeat (2) @(negedge core_clk);
		ss_n = 1'b0;
		edges = 0;
		wr(8'h4E, 8'hB4 ^ {6'h00, m});
		wait_flag();
		check("sck edges", 8'h10, edges[7:0]);
		check("half period", (&m) ? 8'h28 : 8'h50, 8'(t1 - t0));
		check("idle sck", {7'h00, m[1]}, {7'h00, sck_w});
		check("far rx", 8'hB4 ^ {6'h00, m}, m_rx);
		rd(8'h4E, d);
		check("near rx", m_tx, d);
		rd(8'h4D, d);
		check("flag clear", 8'h00, d & 8'hC0);
		ss_n = 1'b1;
	endtask : t_master
	// select pulled low under a master
	task automatic t_fault();
		logic [7:0] d;
		ddr_ss = 1'b0;
		wr(8'h4C, 8'hD0);
		ss_n = 1'b0;
		repeat (8) @(negedge core_clk);
		rd(8'h4C, d);
		check("ctrl after fault", 8'hC0, d);
		rd(8'h4D, d);
		check("fault flag", 8'h80, d & 8'h80);
		check("irq masked", 8'h00, {7'h00, irq});
		gie = 1'b1;
		repeat (3) @(negedge core_clk);
		check("irq", 8'h01, {7'h00, irq});
		ack = 1'b1;
		@(negedge core_clk);
		ack = 1'b0;
		repeat (3) @(negedge core_clk);
		check("irq after ack", 8'h00, {7'h00, irq});
		gie = 1'b0;
		ss_n = 1'b1;
		ddr_ss = 1'b1;
		repeat (8) @(negedge core_clk);
	endtask : t_fault
	// one mode 0 frame of n bits from the bench as master
	task automatic frame(input logic [7:0] b, input int n, output logic [7:0] got);
		ss_n = 1'b0;
		repeat (8) @(negedge core_clk);
		// step off the core clock edges so no link edge meets one
		#1;
		for (int i = 0; i < n; i++) begin
			tb_mosi = b[7 - i];
			#62;
			tb_sck = 1'b1;
			got = {got[6:0], miso_w};
			#63;
			tb_sck = 1'b0;
		end
		@(negedge core_clk);
		ss_n = 1'b1;
		repeat (8) @(negedge core_clk);
		check("miso released", 8'h01, {7'h00, miso_oe_n});
	endtask : frame
	task automatic t_slave();
		logic [7:0] g;
		mode = 2'b00;
		wr(8'h4C, 8'h40);
		wr(8'h4E, 8'h96);
		frame(8'h5B, 8, g);
		check("slave miso", 8'h96, g);
		frame(8'hFF, 3, g);
		frame(8'h2E, 8, g);
		rd(8'h4E, g);
		check("slave rx", 8'h5B, g);
		rd(8'h4E, g);
		check("after partial", 8'h2E, g);
	endtask : t_slave
	initial begin
		repeat (4) @(posedge core_clk);
		@(negedge core_clk);
		reset_n = 1'b1;
		t_regs();
		for (int m = 0; m < 4; m++) t_master(2'(m));
		t_fault();
		t_slave();
		end_of_test();
	end
endmodule : spims_top_test
`default_nettype wire
